//--- verilog/runaway_watchdog_interval_timer.sv
// Contract
// - one counter, interval or runaway mode
// - runaway expiry gives nmi or reset
// - interval mode interrupts every elapsed interval
// - code selects fxx/2^3..2^9, or 2^11
// - period 2^11..2^17 fxx, or 2^19
// - fxx is oscillator clock, halved when bit clear
// - clock select at FF42, resets 00, bit3 zero
// - watch and buzzer fields forwarded untouched
// - run write clears and starts, sticky
// - mode and action bits sticky once set
// - runs in halt, freezes in stop or subclock
module runaway_watchdog_interval_timer #(
    // exponents kept as parameters so a simulation can shorten periods
    parameter int unsigned EXP_BASE = wdt_pkg::PERIOD_EXP_BASE,
    parameter int unsigned EXP_TOP  = wdt_pkg::PERIOD_EXP_TOP
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [15:0] sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    input  wire logic        main_clock_div_select,
    input  wire logic        halt_mode,
    input  wire logic        stop_mode,
    input  wire logic        cpu_on_subsystem_clock,
    output logic             interval_interrupt_request,
    output logic             runaway_nmi_request,
    output logic             runaway_reset_request,
    output logic             watch_clock_sel,
    output logic      [1:0]  buzzer_freq_sel,
    output logic             buzzer_enable_sel,
    output logic      [2:0]  wdt_clock_sel
);

    // register storage
    logic [7:0] timer_clock_select_two;   // shared clock select byte
    logic       run;                      // counting started
    logic       runaway_mode_select;      // 1 runaway, 0 interval
    logic       expiry_action_select;     // 1 reset, 0 nmi

    // strobes
    logic wr_clock_select;                // byte write to clock select
    logic wr_mode;                        // write to mode register
    logic refresh;                        // run bit written as one

    // count path
    logic half_phase;                     // halves the oscillator clock
    logic fxx_tick;                       // one main system clock tick
    logic frozen;                         // stop standby or subclock
    logic count_en;                       // counter advances this cycle
    logic expire;                         // period just ended
    wdt_pkg::expiry_act_t act;            // what an expiry does

    // address decode, the bus is same-clock cpu logic
    // strobes are one-cycle pulses; a read and a write may share a cycle
    assign wr_clock_select = sfr_wr
                          && (sfr_addr == wdt_pkg::CLOCK_SELECT_ADDR);
    assign wr_mode         = sfr_wr && (sfr_addr == wdt_pkg::MODE_ADDR);
    assign refresh         = wr_mode && sfr_wdata[wdt_pkg::RUN_BIT];

    // clock select register, full byte write with bit 3 held low
    // no interlock on rewrites while running: a new code applies to the running count at once
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_clock_select_two <=
                wdt_pkg::CLOCK_SELECT_RESET;
        end else if (wr_clock_select) begin
            // whole byte at once; the later bit 3 assignment wins
            timer_clock_select_two <= sfr_wdata;
            timer_clock_select_two[wdt_pkg::ZERO_BIT] <= 1'b0;
        end
    end

    // run bit: a one clears and starts, a zero is ignored
    // nothing here ever clears it: only a reset stops counting
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            run <= wdt_pkg::MODE_RESET[wdt_pkg::RUN_BIT];
        end else if (refresh) begin
            run <= 1'b1;
        end
    end

    // mode and action bits can only be set by software
    // a mode change alone does not clear the count
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            runaway_mode_select  <=
                wdt_pkg::MODE_RESET[wdt_pkg::RUNAWAY_MODE_BIT];
            expiry_action_select <=
                wdt_pkg::MODE_RESET[wdt_pkg::EXPIRY_ACTION_BIT];
        end else if (wr_mode) begin
            // or-in keeps a set bit set until reset
            runaway_mode_select  <= runaway_mode_select
                | sfr_wdata[wdt_pkg::RUNAWAY_MODE_BIT];
            expiry_action_select <= expiry_action_select
                | sfr_wdata[wdt_pkg::EXPIRY_ACTION_BIT];
        end
    end

    // read data, registered; unmapped addresses read zero
    // the value stands until the next read strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                wdt_pkg::CLOCK_SELECT_ADDR: begin
                    sfr_rdata <= timer_clock_select_two;
                end
                // only run, mode and action bits exist here
                wdt_pkg::MODE_ADDR: begin
                    sfr_rdata <= 8'h00;
                    sfr_rdata[wdt_pkg::RUN_BIT]           <= run;
                    sfr_rdata[wdt_pkg::RUNAWAY_MODE_BIT]  <=
                        runaway_mode_select;
                    sfr_rdata[wdt_pkg::EXPIRY_ACTION_BIT] <=
                        expiry_action_select;
                end
                default: begin
                    sfr_rdata <= 8'h00;
                end
            endcase
        end
    end

    // half-rate phase of the oscillator clock; held while frozen so a
    // resume picks up cleanly; it runs from reset, not from a refresh,
    // so the first slow tick after a refresh may be one clock late
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            half_phase <= 1'b0;
        end else if (!frozen) begin
            half_phase <= ~half_phase;
        end
    end

    // fxx is every clk, or every other clk with the bit clear
    assign fxx_tick = main_clock_div_select | half_phase;

    // halt does not appear here on purpose: counting goes on in halt
    // a frozen counter keeps its value and resumes where it stopped
    assign frozen   = stop_mode | cpu_on_subsystem_clock;
    assign count_en = run && fxx_tick && !frozen;

    // the prescale stage of fxx/2^3..2^11 and the count that follows
    // are folded into one tick count of 2^11..2^19 fxx periods
    expiry_counter #(
        .EXP_BASE (EXP_BASE),
        .EXP_TOP  (EXP_TOP)
    ) u_expiry_counter (
        .clk      (clk),
        .arst_n   (arst_n),
        .clear    (refresh),
        .count_en (count_en),
        .sel      (timer_clock_select_two[
                      wdt_pkg::WDT_SEL_MSB:
                      wdt_pkg::WDT_SEL_LSB]),
        .expire   (expire)
    );

    // one mode at a time: the mode bit picks interval or runaway, the action bit picks nmi or reset
    // in interval mode the action bit is simply not looked at
    always_comb begin
        if (!runaway_mode_select) begin
            act = wdt_pkg::ACT_INTERVAL;
        end else if (expiry_action_select) begin
            act = wdt_pkg::ACT_RESET;
        end else begin
            act = wdt_pkg::ACT_NMI;
        end
    end

    // expiry consequences, one-cycle pulses from flops
    // every request drops back low on the next clock
    // exactly one request per expiry, never two at once
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            interval_interrupt_request <= 1'b0;
            runaway_nmi_request        <= 1'b0;
            runaway_reset_request      <= 1'b0;
        end else begin
            interval_interrupt_request <= 1'b0;
            runaway_nmi_request        <= 1'b0;
            runaway_reset_request      <= 1'b0;
            if (expire) begin
                case (act)
                    wdt_pkg::ACT_INTERVAL: begin
                        interval_interrupt_request <= 1'b1;
                    end
                    wdt_pkg::ACT_NMI: begin
                        runaway_nmi_request <= 1'b1;
                    end
                    wdt_pkg::ACT_RESET: begin
                        runaway_reset_request <= 1'b1;
                    end
                    default: begin
                        runaway_nmi_request <= 1'b0;
                    end
                endcase
            end
        end
    end

    // forwarded fields come straight from the register flops
    // the watch and buzzer units use these; counting ignores them
    assign watch_clock_sel   = timer_clock_select_two[
                                   wdt_pkg::WATCH_SEL_BIT];
    assign buzzer_freq_sel   = timer_clock_select_two[
                                   wdt_pkg::BUZZER_FREQ_MSB:
                                   wdt_pkg::BUZZER_FREQ_LSB];
    assign buzzer_enable_sel = timer_clock_select_two[
                                   wdt_pkg::BUZZER_EN_BIT];
    assign wdt_clock_sel     = timer_clock_select_two[
                                   wdt_pkg::WDT_SEL_MSB:
                                   wdt_pkg::WDT_SEL_LSB];

endmodule

//--- verilog/wdt_pkg.sv
package wdt_pkg;

    // byte-wide special function register addresses
    localparam logic [15:0] CLOCK_SELECT_ADDR = 16'hFF42;
    localparam logic [15:0] MODE_ADDR         = 16'hFFF9;

    // reset values
    localparam logic [7:0]  CLOCK_SELECT_RESET = 8'h00;
    localparam logic [7:0]  MODE_RESET         = 8'h00;

    // clock select register fields
    localparam int unsigned WDT_SEL_LSB      = 0;  // 3-bit period code
    localparam int unsigned WDT_SEL_MSB      = 2;
    localparam int unsigned ZERO_BIT         = 3;  // always reads 0
    localparam int unsigned WATCH_SEL_BIT    = 4;  // forwarded only
    localparam int unsigned BUZZER_FREQ_LSB  = 5;  // forwarded only
    localparam int unsigned BUZZER_FREQ_MSB  = 6;
    localparam int unsigned BUZZER_EN_BIT    = 7;

    // watchdog mode register fields
    localparam int unsigned EXPIRY_ACTION_BIT = 3;  // 0 nmi, 1 reset
    localparam int unsigned RUNAWAY_MODE_BIT  = 4;  // 0 interval
    localparam int unsigned RUN_BIT           = 7;

    // period exponents in main system clock periods
    localparam int unsigned PERIOD_EXP_BASE = 11;  // code 000
    localparam int unsigned PERIOD_EXP_TOP  = 19;  // code 111
    localparam logic [2:0]  SEL_CODE_TOP    = 3'h7;

    // counter wide enough for the longest period
    localparam int unsigned COUNT_W = 20;

    // what happens on expiry, as decoded from the mode register
    typedef enum logic [1:0] {
        ACT_INTERVAL = 2'h0,
        ACT_NMI      = 2'h1,
        ACT_RESET    = 2'h3
    } expiry_act_t;

endpackage

//--- verilog/expiry_counter.sv
// counts main system clock ticks and flags the end of the chosen period
module expiry_counter #(
    parameter int unsigned EXP_BASE = wdt_pkg::PERIOD_EXP_BASE,
    parameter int unsigned EXP_TOP  = wdt_pkg::PERIOD_EXP_TOP
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       clear,
    input  wire logic       count_en,
    input  wire logic [2:0] sel,
    output logic            expire
);

    logic [wdt_pkg::COUNT_W-1:0] count;     // elapsed fxx ticks
    logic [wdt_pkg::COUNT_W-1:0] last;      // terminal count

    // period code to terminal count, codes 0..6 linear, 7 jumps two
    function automatic logic [wdt_pkg::COUNT_W-1:0] last_of(
        input logic [2:0] code
    );
        int unsigned e;
        logic [63:0] span;                  // full-width terminal count
        e = (code == wdt_pkg::SEL_CODE_TOP) ? EXP_TOP
                                            : EXP_BASE + 32'(code);
        span = (64'h1 << e) - 64'h1;
        // narrowed on purpose: the longest period fits the counter
        last_of = span[wdt_pkg::COUNT_W-1:0];
    endfunction

    assign last = last_of(sel);

    // refresh beats a simultaneous expiry, so software is never late
    assign expire = count_en && !clear && (count == last);

    // counter wraps on expiry and keeps going
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else if (count_en) begin
            if (count >= last) begin
                count <= '0;
            end else begin
                count <= count + 1'b1;
            end
        end
    end

endmodule

//--- tb/runaway_wdt_asserts.sv
module runaway_wdt_checker #(
    parameter int unsigned EXP_BASE = 11,
    parameter int unsigned EXP_TOP  = 19
) (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [15:0] sfr_addr,
    input wire logic        sfr_wr,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_wdata,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        main_clock_div_select,
    input wire logic        stop_mode,
    input wire logic        cpu_on_subsystem_clock,
    input wire logic        interval_interrupt_request,
    input wire logic        runaway_nmi_request,
    input wire logic        runaway_reset_request,
    input wire logic [2:0]  wdt_clock_sel
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    wire logic irq = interval_interrupt_request;
    wire logic req = irq | runaway_nmi_request | runaway_reset_request;
    wire logic frz = stop_mode | cpu_on_subsystem_clock; // count held
    wire logic csa = sfr_addr == wdt_pkg::CLOCK_SELECT_ADDR;
    wire logic mda = sfr_addr == wdt_pkg::MODE_ADDR;
    logic [7:0] last_wdata; // write data one cycle back
    always_ff @(posedge clk) begin
        last_wdata <= sfr_wdata;
    end
    // full-rate counting with no register traffic to disturb it
    sequence quiet_run;
        (!sfr_wr && !frz && main_clock_div_select)[*8];
    endsequence
    a_one_request: assert property (
        $onehot0({irq, runaway_nmi_request, runaway_reset_request}))
        else $error("two requests at once");
    a_sel_mirror: assert property (sfr_wr && csa |=>
        wdt_clock_sel == last_wdata[2:0]) else $error("period code lost");
    a_zero_bit: assert property (sfr_rd && csa |=>
        !sfr_rdata[3]) else $error("select bit3 not zero");
    a_unmapped_read: assert property (sfr_rd && !csa && !mda |=>
        sfr_rdata == 8'h00) else $error("hole read not zero");
    a_frozen_quiet: assert property (frz |=> !req)
        else $error("request while frozen");
    a_pulse_once: assert property (req |=> !req)
        else $error("request longer than one cycle");
    a_refresh_delay: assert property (
        sfr_wr && mda && sfr_wdata[7] |=> !req [*8])
        else $error("request too soon after refresh");
    // only meaningful with the shortened period of eight ticks
    a_interval_period: assert property (
        EXP_BASE == 3 && irq && wdt_clock_sel == 3'h0 ##0 quiet_run
        |=> irq) else $error("interval gap wrong");
endmodule

bind runaway_watchdog_interval_timer runaway_wdt_checker #(
    .EXP_BASE(EXP_BASE), .EXP_TOP(EXP_TOP)) chk_i (
    .clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .main_clock_div_select(main_clock_div_select),
    .stop_mode(stop_mode), .cpu_on_subsystem_clock(cpu_on_subsystem_clock),
    .interval_interrupt_request(interval_interrupt_request),
    .runaway_nmi_request(runaway_nmi_request),
    .runaway_reset_request(runaway_reset_request),
    .wdt_clock_sel(wdt_clock_sel));

//--- tb/cpu_irq_model.sv
// system reset logic: a runaway reset request resets the device
module cpu_irq_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic runaway_reset_request,
    output logic      sys_rst_n
);
    logic [2:0] hold; // reset cycles still to run
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold <= 3'h0;
        end else if (runaway_reset_request) begin
            hold <= 3'h4;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end
    end
    assign sys_rst_n = hold == 3'h0;
endmodule

//--- tb/runaway_watchdog_interval_timer_test.sv
module runaway_watchdog_interval_timer_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int EB = 3; // shortened period exponents
    localparam int ET = 5;
    localparam logic [15:0] CSA = wdt_pkg::CLOCK_SELECT_ADDR;
    localparam logic [15:0] MA = wdt_pkg::MODE_ADDR;
    logic        clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic        full = 1'b1, halt = 1'b0, stop = 1'b0, sub = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  rdata;
    logic [2:0]  wsel, seen; // seen is {reset, nmi, interval}
    logic [1:0]  bfreq;
    logic        irq, nmi, rreq, sys_rst_n, watch, ben;
    wire logic   arst_n = rst_n & sys_rst_n;
    int          n_errors = 0, checked = 0, cyc;
    always #5 clk = ~clk;
    runaway_watchdog_interval_timer #(.EXP_BASE(EB), .EXP_TOP(ET)) dut (
        .clk(clk), .arst_n(arst_n), .sfr_addr(addr), .sfr_wr(wr_en),
        .sfr_rd(rd_en), .sfr_wdata(wdata), .sfr_rdata(rdata),
        .main_clock_div_select(full), .halt_mode(halt), .stop_mode(stop),
        .cpu_on_subsystem_clock(sub), .interval_interrupt_request(irq),
        .runaway_nmi_request(nmi), .runaway_reset_request(rreq),
        .watch_clock_sel(watch), .buzzer_freq_sel(bfreq),
        .buzzer_enable_sel(ben), .wdt_clock_sel(wsel));
    cpu_irq_model cpu (.clk(clk), .rst_n(rst_n),
        .runaway_reset_request(rreq), .sys_rst_n(sys_rst_n));
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(string what, logic [15:0] a, logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk(what, exp, rdata);
    endtask
    // bounded wait for the next request of any kind
    task automatic wait_req(int max);
        cyc = 0;
        seen = 3'h0;
        while (seen == 3'h0 && cyc < max) begin
            @(posedge clk);
            #1 cyc++;
            seen = {rreq, nmi, irq};
        end
        if (seen == 3'h0) begin
            n_errors++;
            $display("BAD request expected 1 seen 0");
            wrap_up();
        end
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task automatic s_regs();
        rd("select", CSA, 8'h00);
        rd("mode", MA, 8'h00);
        wr(CSA, 8'hFF);
        rd("select", CSA, 8'hF7);
        chk("fwd", 8'hF7, {ben, bfreq, watch, 1'b0, wsel});
        // uneven pattern so swapped field bits would show
        wr(CSA, 8'hAD);
        rd("select", CSA, 8'hA5);
        chk("fwd", 8'hA5, {ben, bfreq, watch, 1'b0, wsel});
        rd("hole", 16'hFF43, 8'h00);
    endtask
    // every code in interval mode, each after a reset so none is rewritten
    task automatic s_codes();
        for (int c = 0; c < 8; c++) begin
            int n;
            n = (c == 7) ? 1 << ET : 1 << (EB + c);
            do_reset();
            wr(CSA, 8'(c));
            wr(MA, 8'h80);
            wait_req(2 * n);
            chk("first", 16'(n), 16'(cyc));
            chk("kind", 3'h1, seen);
            wait_req(2 * n);
            chk("gap", 16'(n), 16'(cyc));
        end
    endtask
    // half-rate fxx: first tick may be one clock late
    task automatic s_slow();
        do_reset();
        full <= 1'b0;
        wr(MA, 8'h80);
        wait_req(40);
        chk("slow first", 16'(1 << EB), 16'(cyc >> 1));
        wait_req(40);
        chk("slow gap", 16'(2 << EB), 16'(cyc));
        full <= 1'b1;
    endtask
    task automatic s_freeze();
        for (int i = 0; i < 2; i++) begin
            do_reset();
            wr(MA, 8'h80);
            {sub, stop} <= 2'h1 << i;
            repeat (20) @(posedge clk);
            {sub, stop} <= 2'h0;
            wait_req(40);
            chk("frozen", 16'(1 << EB), 16'(cyc));
        end
    endtask
    // refreshed runaway, then let it expire; halt must not stop it
    task automatic s_runaway();
        for (int i = 0; i < 2; i++) begin
            do_reset();
            halt <= 1'b1;
            wr(MA, i ? 8'h98 : 8'h90);
            repeat (3) begin
                repeat (4) @(posedge clk);
                wr(MA, 8'h80);
            end
            rd("sticky", MA, i ? 8'h98 : 8'h90);
            wait_req(40);
            // the read-back used two of the period's edges
            chk("late", 16'((1 << EB) - 2), 16'(cyc));
            chk("action", i ? 3'h4 : 3'h2, seen);
            repeat (6) @(posedge clk);
            rd("after", MA, i ? 8'h00 : 8'h90);
        end
    endtask
    initial begin
        do_reset();
        s_regs();
        s_codes();
        s_slow();
        s_freeze();
        s_runaway();
        wrap_up();
    end
endmodule
